// >>> common/mcc_pkg.sv
// Constants, types and helper functions for the monitor console control block
package mcc_pkg;

	localparam int CLK_KHZ = 125000;
	localparam int HOLD_MS = 2000;
	localparam int SLOT_MS = 125;
	localparam int FLASH_MS = 100;
	localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
	localparam int SLOT_CYC = SLOT_MS * CLK_KHZ;
	localparam int FLASH_CYC = FLASH_MS * CLK_KHZ;

	localparam int SEL_N = 7;
	localparam int COMM_N = 3;
	localparam int KEY_W = 18;
	localparam int SYNC_W = 26;

	localparam logic [2:0] NO_SRC = 3'h0;
	localparam logic [2:0] SRC_RESET = 3'h1;
	localparam logic [2:0] LVL_RESET = 3'h4;
	localparam logic [2:0] LVL_MAX = 3'h7;
	localparam logic [2:0] LVL_MIN = 3'h0;
	localparam logic [7:0] LVL_DEADBAND = 8'h02;
	localparam logic [4:0] TONE_BELOW_DB = 5'h0A;
	localparam logic [2:0] SLOT_FIRST = 3'h0;
	localparam logic [2:0] SLOT_SECOND = 3'h2;
	localparam logic [4:0] DIM_DB [6] = '{5'h00, 5'h1E, 5'h19, 5'h14, 5'h0F, 5'h0A};

	typedef enum logic [1:0] {
		CR_STEREO = 2'b00,
		CR_LEFT = 2'b01,
		CR_RIGHT = 2'b10
	} mcc_cr_mode_t;

	// Lowest pressed input wins when several arrive in the same cycle
	function automatic logic [2:0] mcc_enc7(input logic [6:0] k);
		logic [2:0] c;
		c = NO_SRC;
		for (int i = SEL_N - 1; i >= 0; i--)
			if (k[i])
				c = 3'(i + 1);
		return c;
	endfunction : mcc_enc7

	function automatic logic [6:0] mcc_col_led(input logic [2:0] src, input logic [6:0] mono,
		input logic blink);
		logic [6:0] v;
		v = 7'h00;
		for (int i = 0; i < SEL_N; i++)
			v[i] = (src == 3'(i + 1)) && (!mono[i] || blink);
		return v;
	endfunction : mcc_col_led

endpackage : mcc_pkg

// >>> common/mcc_tick_if.sv
// Blink phase carrier between the blink timer and the console logic
`timescale 1ns/10ps
`default_nettype none
interface mcc_tick_if;
	logic [2:0] slot;
	modport src(output slot);
	modport dst(input slot);
endinterface : mcc_tick_if
`default_nettype wire

// >>> core/mcc_blink.sv
// Free-running blink slot timer for the console LEDs
`timescale 1ns/10ps
`default_nettype none
module mcc_blink
	import mcc_pkg::*;
#(
	parameter int SLOT_CYCLES = SLOT_CYC
)(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	mcc_tick_if.src tick
);

	logic [31:0] cnt_r;
	logic [2:0] slot_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			cnt_r <= 32'h0;
			slot_r <= 3'h0;
		end
		else if (cnt_r == 32'(SLOT_CYCLES - 1))
		begin
			cnt_r <= 32'h0;
			slot_r <= slot_r + 3'h1;
		end
		else
			cnt_r <= cnt_r + 32'h1;
	end

	assign tick.slot = slot_r;

endmodule : mcc_blink
`default_nettype wire

// >>> core/mcc_console.sv
// Monitor console control: key scan, routing state, communications and LEDs
`timescale 1ns/10ps
`default_nettype none
module mcc_console
	import mcc_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int SLOT_CYCLES = SLOT_CYC,
	parameter int FLASH_CYCLES = FLASH_CYC
)(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [6:0] input_select_keys_i,
	input wire logic key_phones_i,
	input wire logic key_dub_i,
	input wire logic key_ab_i,
	input wire logic key_dim_i,
	input wire logic key_mono_i,
	input wire logic key_studio_i,
	input wire logic [2:0] key_comm_i,
	input wire logic key_up_i,
	input wire logic key_dn_i,
	input wire logic [7:0] cr_level_i,
	input wire logic [6:0] cfg_mono_in_i,
	input wire logic cfg_st_follows_hp_i,
	input wire logic cfg_hp_follows_cr_i,
	input wire logic cfg_mono_latch_i,
	input wire logic cfg_auto_dim_off_i,
	input wire logic [2:0] cfg_comm_latch_i,
	input wire logic cfg_talk_add_i,
	input wire logic cfg_slate_hp_i,
	input wire logic cfg_tone_en_i,
	input wire logic [5:0] cfg_dim_sel_i,
	output logic [2:0] cr_src_o,
	output logic [2:0] hp_src_o,
	output logic [2:0] st_src_o,
	output logic [2:0] dub_src_o,
	output logic pair_b_o,
	output logic [1:0] cr_mode_o,
	output logic mono_o,
	output logic studio_on_o,
	output logic dim_o,
	output logic dim_mute_o,
	output logic [4:0] dim_db_o,
	output logic [2:0] comm_active_o,
	output logic [8:0] comm_level_o,
	output logic [2:0] hp_comm_level_o,
	output logic studio_mic_o,
	output logic hp_mic_replace_o,
	output logic hp_mic_mix_o,
	output logic dub_mic_o,
	output logic tone_on_o,
	output logic [2:0] tone_level_o,
	output logic [4:0] tone_atten_db_o,
	output logic [6:0] led_cr_o,
	output logic [6:0] led_hp_o,
	output logic [6:0] led_dub_o,
	output logic led_a_o,
	output logic led_b_o,
	output logic led_dim_o,
	output logic led_mono_o,
	output logic led_studio_o,
	output logic [2:0] led_comm_o
);

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic [KEY_W-1:0] prev_r;
	logic [6:0] sel_s, sel_p;
	logic ph_s, dub_s, ab_s, dim_s, mono_s, st_s, up_s, dn_s;
	logic ph_p, dub_p, ab_p, dim_p, mono_p, st_p, up_p, dn_p;
	logic [2:0] comm_s, comm_p, comm_e;
	logic [7:0] lvl_s;
	logic ab_e, dim_e, mono_e, st_e, up_e, dn_e, both_s, both_e;
	logic [2:0] sel_code;
	logic [2:0] cr_src_r, hp_src_r, st_src_r, dub_src_r, st_src_nxt;
	logic pair_b_r, mono_r, studio_on_r, dim_user_r;
	logic [7:0] lvl_ref_r, lvl_diff;
	logic lvl_moved;
	logic [31:0] hold_cnt_r, st_fl_r, cm_fl_r;
	logic hold_done_r, hold_ok, hold_fire;
	mcc_cr_mode_t cr_mode_r;
	logic [2:0] comm_r;
	logic [2:0] lvl_r [COMM_N];
	logic [2:0] cur_lvl;
	logic step_up, step_dn, step_ok, comm_any, pair_on, blink;
	logic [4:0] dim_db;

	mcc_tick_if tick_if();

	mcc_blink #(
		.SLOT_CYCLES(SLOT_CYCLES)
	) u_blink (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.tick(tick_if)
	);

	// Every key and the level pot come from the panel, so all pass two flops
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end
		else
		begin
			sync1_r <= {input_select_keys_i, key_phones_i, key_dub_i, key_ab_i, key_dim_i,
				key_mono_i, key_studio_i, key_comm_i, key_up_i, key_dn_i, cr_level_i};
			sync2_r <= sync1_r;
			prev_r <= sync2_r[SYNC_W-1:8];
		end
	end

	assign {sel_s, ph_s, dub_s, ab_s, dim_s, mono_s, st_s, comm_s, up_s, dn_s, lvl_s} = sync2_r;
	assign {sel_p, ph_p, dub_p, ab_p, dim_p, mono_p, st_p, comm_p, up_p, dn_p} = prev_r;
	assign ab_e = ab_s & ~ab_p;
	assign dim_e = dim_s & ~dim_p;
	assign mono_e = mono_s & ~mono_p;
	assign st_e = st_s & ~st_p;
	assign up_e = up_s & ~up_p;
	assign dn_e = dn_s & ~dn_p;
	assign comm_e = comm_s & ~comm_p;
	assign both_s = up_s & dn_s;
	assign both_e = both_s & ~(up_p & dn_p);
	assign sel_code = mcc_enc7(sel_s & ~sel_p);
	assign comm_any = comm_r != 3'h0;
	assign blink = tick_if.slot[1];

	// Source selection; a modifier key decides which column is changed
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			cr_src_r <= SRC_RESET;
			hp_src_r <= SRC_RESET;
			dub_src_r <= SRC_RESET;
		end
		else if (sel_code != NO_SRC)
		begin
			if (ph_s)
				hp_src_r <= sel_code;
			else if (dub_s)
				dub_src_r <= sel_code;
			else
			begin
				cr_src_r <= sel_code;
				if (cfg_hp_follows_cr_i)
					hp_src_r <= sel_code;
			end
		end
		else if (both_e)
		begin
			if (ph_s)
				hp_src_r <= NO_SRC;
			else if (dub_s)
				dub_src_r <= NO_SRC;
		end
	end

	assign st_src_nxt = cfg_st_follows_hp_i ? hp_src_r : cr_src_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			st_src_r <= SRC_RESET;
		else
			st_src_r <= st_src_nxt;
	end

	// Studio LED goes dark briefly when an on feed changes source
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			st_fl_r <= 32'h0;
		else if (studio_on_r && st_src_nxt != st_src_r)
			st_fl_r <= 32'(FLASH_CYCLES);
		else if (st_fl_r != 32'h0)
			st_fl_r <= st_fl_r - 32'h1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pair_b_r <= 1'b0;
			studio_on_r <= 1'b0;
			mono_r <= 1'b0;
		end
		else
		begin
			if (ab_e)
				pair_b_r <= ~pair_b_r;
			if (st_e)
				studio_on_r <= ~studio_on_r;
			if (cfg_mono_latch_i)
				mono_r <= mono_e ? ~mono_r : mono_r;
			else
				mono_r <= mono_s;
		end
	end

	// Reference follows the pot except while user dim is engaged outside talkback, so the tear of a
	// two-flop synchronised multi-bit pot value is absorbed by the deadband
	assign lvl_diff = (lvl_s > lvl_ref_r) ? lvl_s - lvl_ref_r : lvl_ref_r - lvl_s;
	assign lvl_moved = lvl_diff > LVL_DEADBAND;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			dim_user_r <= 1'b0;
			lvl_ref_r <= 8'h00;
		end
		else if (dim_e)
		begin
			dim_user_r <= ~dim_user_r;
			lvl_ref_r <= lvl_s;
		end
		else if (cfg_auto_dim_off_i && dim_user_r && !comm_any && lvl_moved)
			dim_user_r <= 1'b0;
		else if (!dim_user_r || comm_any)
			lvl_ref_r <= lvl_s;
	end

	// Long hold of both level keys, only outside communications and modifiers
	assign hold_ok = both_s && !ph_s && !dub_s && !comm_any;
	assign hold_fire = hold_ok && !hold_done_r && hold_cnt_r == 32'(HOLD_CYCLES - 1);

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || !hold_ok)
		begin
			hold_cnt_r <= 32'h0;
			hold_done_r <= 1'b0;
		end
		else if (hold_fire)
			hold_done_r <= 1'b1;
		else if (!hold_done_r)
			hold_cnt_r <= hold_cnt_r + 32'h1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			cr_mode_r <= CR_STEREO;
		else if (hold_fire)
		begin
			unique case (cr_mode_r)
				CR_STEREO: cr_mode_r <= CR_LEFT;
				CR_LEFT: cr_mode_r <= CR_RIGHT;
				CR_RIGHT: cr_mode_r <= CR_STEREO;
				default: cr_mode_r <= CR_STEREO;
			endcase
		end
	end

	// A function starts only from idle and only for a single fresh press
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			comm_r <= 3'h0;
		else if (!comm_any)
		begin
			if ($onehot(comm_e))
				comm_r <= comm_e;
		end
		else if ((comm_e & comm_r & cfg_comm_latch_i) != 3'h0)
			comm_r <= 3'h0;
		else if ((comm_r & ~cfg_comm_latch_i & ~comm_s) != 3'h0)
			comm_r <= 3'h0;
	end

	assign step_up = up_e & ~dn_s;
	assign step_dn = dn_e & ~up_s;
	assign cur_lvl = comm_r[0] ? lvl_r[0] : (comm_r[1] ? lvl_r[1] : lvl_r[2]);
	assign step_ok = comm_any && ((step_up && cur_lvl != LVL_MAX) ||
		(step_dn && cur_lvl != LVL_MIN));

	always_ff @(posedge clk_sys_i)
	begin
		for (int i = 0; i < COMM_N; i++)
		begin
			if (rst_i)
				lvl_r[i] <= LVL_RESET;
			else if (comm_r[i] && step_up && lvl_r[i] != LVL_MAX)
				lvl_r[i] <= lvl_r[i] + 3'h1;
			else if (comm_r[i] && step_dn && lvl_r[i] != LVL_MIN)
				lvl_r[i] <= lvl_r[i] - 3'h1;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			cm_fl_r <= 32'h0;
		else if (step_ok)
			cm_fl_r <= 32'(FLASH_CYCLES);
		else if (cm_fl_r != 32'h0)
			cm_fl_r <= cm_fl_r - 32'h1;
	end

	// A code that is not one-hot falls back to mute, the safe side
	always_comb
	begin
		dim_db = DIM_DB[0];
		for (int i = 1; i < 6; i++)
			if (cfg_dim_sel_i == 6'(6'h01 << i))
				dim_db = DIM_DB[i];
	end

	assign pair_on = (cr_mode_r == CR_STEREO) || !(tick_if.slot == SLOT_FIRST ||
		(cr_mode_r == CR_RIGHT && tick_if.slot == SLOT_SECOND));

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			led_cr_o <= 7'h00;
			led_hp_o <= 7'h00;
			led_dub_o <= 7'h00;
			led_a_o <= 1'b0;
			led_b_o <= 1'b0;
			led_dim_o <= 1'b0;
			led_mono_o <= 1'b0;
			led_studio_o <= 1'b0;
			led_comm_o <= 3'h0;
		end
		else
		begin
			led_cr_o <= mcc_col_led(cr_src_r, cfg_mono_in_i, blink);
			led_hp_o <= mcc_col_led(hp_src_r, cfg_mono_in_i, blink);
			led_dub_o <= mcc_col_led(dub_src_r, cfg_mono_in_i, blink);
			led_a_o <= ~pair_b_r & pair_on;
			led_b_o <= pair_b_r & pair_on;
			led_dim_o <= dim_user_r | comm_any;
			led_mono_o <= mono_r;
			led_studio_o <= studio_on_r && st_fl_r == 32'h0;
			led_comm_o <= (comm_r | {1'b0, cfg_slate_hp_i & comm_r[2], 1'b0}) &
				{3{cm_fl_r == 32'h0}};
		end
	end

	// Any talkback dims the control room to avoid feedback
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			dim_o <= 1'b0;
			dim_mute_o <= 1'b0;
			dim_db_o <= 5'h00;
			hp_comm_level_o <= LVL_RESET;
			studio_mic_o <= 1'b0;
			hp_mic_replace_o <= 1'b0;
			hp_mic_mix_o <= 1'b0;
			dub_mic_o <= 1'b0;
			tone_on_o <= 1'b0;
			tone_level_o <= LVL_RESET;
		end
		else
		begin
			dim_o <= dim_user_r | comm_any;
			dim_mute_o <= dim_db == DIM_DB[0];
			dim_db_o <= dim_db;
			hp_comm_level_o <= (comm_r[2] && cfg_slate_hp_i) ? lvl_r[2] : lvl_r[1];
			studio_mic_o <= comm_r[0];
			hp_mic_replace_o <= comm_r[1] & ~cfg_talk_add_i;
			hp_mic_mix_o <= (comm_r[1] & cfg_talk_add_i) | (comm_r[2] & cfg_slate_hp_i);
			dub_mic_o <= comm_r[2];
			tone_on_o <= comm_r[2] & cfg_tone_en_i;
			tone_level_o <= lvl_r[2];
		end
	end

	assign tone_atten_db_o = TONE_BELOW_DB;
	assign cr_src_o = cr_src_r;
	assign hp_src_o = hp_src_r;
	assign st_src_o = st_src_r;
	assign dub_src_o = dub_src_r;
	assign pair_b_o = pair_b_r;
	assign cr_mode_o = cr_mode_r;
	assign mono_o = mono_r;
	assign studio_on_o = studio_on_r;
	assign comm_active_o = comm_r;
	assign comm_level_o = {lvl_r[2], lvl_r[1], lvl_r[0]};

	cr_select_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(sel_code != NO_SRC && !ph_s && !dub_s) |=> cr_src_r == $past(sel_code))
		else $error("control-room source not taken");
	hp_follow_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(sel_code != NO_SRC && !ph_s && !dub_s && cfg_hp_follows_cr_i)
		|=> hp_src_r == $past(sel_code))
		else $error("headphone did not follow");
	studio_eq_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cfg_st_follows_hp_i |=> st_src_r == $past(hp_src_r))
		else $error("studio differs from headphones");
	hp_none_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ph_s && both_e && sel_code == NO_SRC) |=> hp_src_r == NO_SRC ##1 led_hp_o == 7'h00)
		else $error("headphone none not selected");
	pair_toggle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ab_e |=> pair_b_r != $past(pair_b_r))
		else $error("pair did not alternate");
	dim_toggle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		dim_e |=> dim_user_r != $past(dim_user_r) ##1 dim_o == $past(dim_user_r | comm_any))
		else $error("dim did not toggle");
	auto_dim_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(cfg_auto_dim_off_i && dim_user_r && !comm_any && lvl_moved && !dim_e) |=> !dim_user_r)
		else $error("auto dim off missed");
	comm_dim_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(comm_any && !dim_e) |=> dim_user_r == $past(dim_user_r))
		else $error("dim cancelled during talkback");
	comm_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!comm_any && comm_e != 3'h0 && !$onehot(comm_e)) |=> !comm_any)
		else $error("several functions started");
	mode_cycle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		hold_fire |=> cr_mode_r != $past(cr_mode_r) && hold_done_r)
		else $error("mode did not advance");
	studio_led_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!studio_on_r |=> !led_studio_o)
		else $error("studio LED lit while off");
	level_step_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(comm_r[0] && step_up && lvl_r[0] != LVL_MAX) |=> lvl_r[0] == $past(lvl_r[0]) + 3'h1)
		else $error("level did not step");

endmodule : mcc_console
`default_nettype wire

// >>> tb/mcc_far_model.sv
// Far-end controller model that counts the routing updates it would receive
`timescale 1ns/10ps
`default_nettype none
module mcc_far_model
	import mcc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [2:0] cr_src_i,
	input wire logic [2:0] hp_src_i,
	input wire logic [2:0] st_src_i,
	input wire logic [2:0] dub_src_i,
	input wire logic pair_b_i,
	input wire logic dim_i,
	output logic [15:0] msg_cnt_o
);
	logic [13:0] last_r;
	// Each change of routing state stands for one message on the link
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			msg_cnt_o <= 16'h0000;
		else if (last_r != {cr_src_i, hp_src_i, st_src_i, dub_src_i, pair_b_i, dim_i})
			msg_cnt_o <= msg_cnt_o + 16'h0001;
		last_r <= {cr_src_i, hp_src_i, st_src_i, dub_src_i, pair_b_i, dim_i};
	end
endmodule : mcc_far_model
`default_nettype wire

// >>> tb/tb_monitor_console_control.sv
// Self-checking bench for the monitor console control block
`timescale 1ns/10ps
`default_nettype none
`define CMP(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_monitor_console_control;
	import mcc_pkg::*;
	localparam logic [17:0] K_PH = 18'h00080, K_DUB = 18'h00100, K_AB = 18'h00200;
	localparam logic [17:0] K_DIM = 18'h00400, K_MONO = 18'h00800, K_STU = 18'h01000;
	localparam logic [17:0] K_C0 = 18'h02000, K_C1 = 18'h04000, K_C2 = 18'h08000;
	localparam logic [17:0] K_UP = 18'h10000, K_DN = 18'h20000, K_BOTH = 18'h30000;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [17:0] kv = '0;
	logic [6:0] input_select_keys_i, cfg_mono_in_i = '0;
	logic [2:0] key_comm_i, cfg_comm_latch_i = 3'h4;
	logic key_phones_i, key_dub_i, key_ab_i, key_dim_i, key_mono_i, key_studio_i, key_up_i, key_dn_i;
	logic cfg_st_follows_hp_i = 0, cfg_hp_follows_cr_i = 0, cfg_mono_latch_i = 0;
	logic cfg_auto_dim_off_i = 0, cfg_talk_add_i = 0, cfg_slate_hp_i = 1, cfg_tone_en_i = 1;
	logic [5:0] cfg_dim_sel_i = 6'h01;
	logic [7:0] cr_level_i = 8'h10;
	logic [2:0] cr_src_o, hp_src_o, st_src_o, dub_src_o, comm_active_o, hp_comm_level_o;
	logic [2:0] tone_level_o, led_comm_o;
	logic [1:0] cr_mode_o;
	logic [4:0] dim_db_o, tone_atten_db_o;
	logic [8:0] comm_level_o;
	logic [6:0] led_cr_o, led_hp_o, led_dub_o;
	logic pair_b_o, mono_o, studio_on_o, dim_o, dim_mute_o, studio_mic_o, hp_mic_replace_o;
	logic hp_mic_mix_o, dub_mic_o, tone_on_o, led_a_o, led_b_o, led_dim_o, led_mono_o, led_studio_o;
	logic [7:0] mid;
	logic [15:0] msg_cnt;
	int n_fail = 0, compares = 0, sd, cd, a, c, k, n;
	int m_cr = 1, m_hp = 1, m_st = 1, m_dub = 1, m_b = 0, m_mode = 0, m_dim = 0, m_stu = 0, m_act = 0;
	int lvl[$] = {4, 4, 4};
	int dbt[6] = '{0, 30, 25, 20, 15, 10};
	assign {key_dn_i, key_up_i, key_comm_i, key_studio_i, key_mono_i, key_dim_i, key_ab_i, key_dub_i,
		key_phones_i, input_select_keys_i} = kv;
	always #4 clk_sys_i = ~clk_sys_i;
	// Dark-cycle counters; only meaningful while the LED is meant to be lit
	always @(negedge clk_sys_i)
	begin
		sd += !led_studio_o;
		cd += !led_comm_o[2];
	end
	mcc_console #(.HOLD_CYCLES(40), .SLOT_CYCLES(4), .FLASH_CYCLES(3)) i_mcc_console (
		.clk_sys_i, .rst_i, .input_select_keys_i, .key_phones_i, .key_dub_i, .key_ab_i,
		.key_dim_i, .key_mono_i, .key_studio_i, .key_comm_i, .key_up_i, .key_dn_i, .cr_level_i,
		.cfg_mono_in_i, .cfg_st_follows_hp_i, .cfg_hp_follows_cr_i, .cfg_mono_latch_i,
		.cfg_auto_dim_off_i, .cfg_comm_latch_i, .cfg_talk_add_i, .cfg_slate_hp_i, .cfg_tone_en_i,
		.cfg_dim_sel_i, .cr_src_o, .hp_src_o, .st_src_o, .dub_src_o, .pair_b_o, .cr_mode_o,
		.mono_o, .studio_on_o, .dim_o, .dim_mute_o, .dim_db_o, .comm_active_o, .comm_level_o,
		.hp_comm_level_o, .studio_mic_o, .hp_mic_replace_o, .hp_mic_mix_o, .dub_mic_o,
		.tone_on_o, .tone_level_o, .tone_atten_db_o, .led_cr_o, .led_hp_o, .led_dub_o,
		.led_a_o, .led_b_o, .led_dim_o, .led_mono_o, .led_studio_o, .led_comm_o);
	mcc_far_model i_mcc_far_model (.clk_sys_i, .rst_i, .cr_src_i(cr_src_o), .hp_src_i(hp_src_o),
		.st_src_i(st_src_o), .dub_src_i(dub_src_o), .pair_b_i(pair_b_o), .dim_i(dim_o),
		.msg_cnt_o(msg_cnt));
	function automatic logic [6:0] oh(input int s);
		return (s > 0) ? 7'(1 << (s - 1)) : 7'h00;
	endfunction : oh
	task automatic final_report();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step
	// Modifier h is held around the press of v; mid is sampled while v is held
	task automatic hit(input logic [17:0] h, input logic [17:0] v);
		kv = h;
		step(2);
		sd = 0;
		cd = 0;
		kv = h | v;
		step(5);
		mid = {hp_mic_mix_o, hp_mic_replace_o, studio_mic_o, dub_mic_o, comm_active_o, mono_o};
		step(2);
		kv = h;
		step(2);
		kv = '0;
		step(6);
	endtask : hit
	task automatic model(input logic [17:0] h, input logic [17:0] v);
		k = 0;
		for (int i = 6; i >= 0; i--)
			if (v[i])
				k = i + 1;
		if (k > 0 && h[7])
			m_hp = k;
		if (k > 0 && h[8:7] == 2'b10)
			m_dub = k;
		if (k > 0 && h[8:7] == 2'b00)
			m_cr = k;
		if (k > 0 && h[8:7] == 2'b00 && cfg_hp_follows_cr_i)
			m_hp = k;
		if (v[17:16] == 2'b11 && h[7])
			m_hp = 0;
		else if (v[17:16] == 2'b11 && h[8])
			m_dub = 0;
		m_b ^= v[9];
		m_dim ^= v[10];
		m_stu ^= v[12];
		m_st = cfg_st_follows_hp_i ? m_hp : m_cr;
	endtask : model
	task automatic chk();
		`CMP(cr_src_o, 3'(m_cr))
		`CMP(led_cr_o, oh(m_cr))
		`CMP(hp_src_o, 3'(m_hp))
		`CMP(led_hp_o, oh(m_hp))
		`CMP(st_src_o, 3'(m_st))
		`CMP(dub_src_o, 3'(m_dub))
		`CMP(led_dub_o, oh(m_dub))
		`CMP(pair_b_o, 1'(m_b))
		`CMP(cr_mode_o, 2'(m_mode))
		`CMP(dim_o, 1'(m_dim | (m_act != 0)))
		`CMP(led_dim_o, 1'(m_dim | (m_act != 0)))
		`CMP(studio_on_o, 1'(m_stu))
		`CMP(led_studio_o, 1'(m_stu))
		`CMP(comm_level_o, {3'(lvl[2]), 3'(lvl[1]), 3'(lvl[0])})
	endtask : chk
	task automatic act(input logic [17:0] h, input logic [17:0] v);
		int p;
		p = m_st;
		hit(h, v);
		model(h, v);
		chk();
		if (m_stu && !v[12])
			`CMP(sd, (m_st != p) ? 3 : 0)
	endtask : act
	task automatic dark(output int da, output int dc);
		da = 0;
		dc = 0;
		repeat (32)
		begin
			step(1);
			da += !(m_b ? led_b_o : led_a_o);
			dc += !led_cr_o[m_cr - 1];
		end
	endtask : dark
	// Long hold well past the shortened hold count, then one mode step
	task automatic cyc(input int off);
		kv = K_BOTH;
		step(50);
		kv = '0;
		step(6);
		m_mode = (m_mode + 1) % 3;
		chk();
		dark(a, c);
		`CMP(a, off)
	endtask : cyc
	initial
	begin
		void'($urandom(32'hC38D599E));
		cr_level_i = 8'($urandom % 64);
		step(4);
		rst_i = 1'b0;
		step(2);
		chk();
		`CMP(tone_atten_db_o, 5'h0A)
		cfg_hp_follows_cr_i = 1;
		act(0, K_STU);
		for (int j = 0; j < 4; j++)
			act(0, 18'(1 << ($urandom % 7)));
		act(K_PH, 18'h00010);
		act(K_PH, K_BOTH);
		cfg_st_follows_hp_i = 1;
		m_st = m_hp;
		step(6);
		act(K_PH, 18'h00004);
		act(0, 18'h00040);
		act(K_DUB, 18'h00002);
		act(K_DUB, K_BOTH);
		cfg_hp_follows_cr_i = 0;
		for (int j = 0; j < 3; j++)
			act(0, 18'(1 << ($urandom % 7)));
		act(0, K_STU);
		cfg_mono_in_i = 7'h7F;
		step(2);
		dark(a, c);
		`CMP(c, 16)
		cfg_mono_in_i = 7'h00;
		act(0, K_AB);
		dark(a, c);
		`CMP(a, 0)
		cyc(4);
		act(0, K_AB);
		cyc(8);
		cyc(0);
		for (int i = 0; i < 6; i++)
		begin
			cfg_dim_sel_i = 6'(1 << i);
			step(3);
			`CMP(dim_db_o, 5'(dbt[i]))
			`CMP(dim_mute_o, 1'(i == 0))
		end
		cfg_dim_sel_i = 6'h03;
		step(3);
		`CMP({dim_mute_o, dim_db_o}, 6'h20)
		cfg_dim_sel_i = 6'h20;
		act(0, K_DIM);
		cr_level_i += 8'h20;
		step(6);
		chk();
		act(0, K_DIM);
		cfg_auto_dim_off_i = 1;
		act(0, K_DIM);
		cr_level_i += 8'h20;
		step(6);
		m_dim = 0;
		chk();
		hit(0, K_MONO);
		`CMP(mid[0], 1'b1)
		`CMP(mono_o, 1'b0)
		cfg_mono_latch_i = 1;
		hit(0, K_MONO);
		`CMP(mono_o, 1'b1)
		`CMP(led_mono_o, 1'b1)
		hit(0, K_MONO);
		`CMP(mono_o, 1'b0)
		hit(0, K_C0);
		`CMP(mid[5:1], 5'b10001)
		`CMP(comm_active_o, 3'h0)
		hit(0, K_C0 | K_C1);
		`CMP(mid[3:1], 3'h0)
		hit(0, K_C1);
		`CMP(mid[7:6], 2'b01)
		cfg_talk_add_i = 1;
		hit(0, K_C1);
		`CMP(mid[7:6], 2'b10)
		act(0, K_DIM);
		hit(0, K_C2);
		m_act = 4;
		`CMP({comm_active_o, led_comm_o[2]}, 4'h9)
		`CMP({hp_mic_mix_o, hp_comm_level_o}, {1'b1, 3'(lvl[2])})
		`CMP({tone_on_o, tone_level_o}, {1'b1, 3'(lvl[2])})
		`CMP({dub_mic_o, led_comm_o[1]}, 2'b11)
		hit(0, K_C0);
		`CMP(mid[3:1], 3'h4)
		cr_level_i += 8'h20;
		step(6);
		for (int i = 0; i < 13; i++)
		begin
			hit(0, (i < 5) ? K_UP : K_DN);
			n = (i < 5) ? ((lvl[2] < 7) ? lvl[2] + 1 : 7) : ((lvl[2] > 0) ? lvl[2] - 1 : 0);
			`CMP(cd, (n != lvl[2]) ? 3 : 0)
			lvl[2] = n;
			chk();
			`CMP(tone_level_o, 3'(n))
		end
		hit(0, K_C2);
		m_act = 0;
		chk();
		cfg_slate_hp_i = 0;
		cfg_tone_en_i = 0;
		hit(0, K_C2);
		`CMP({hp_mic_mix_o, tone_on_o, led_comm_o[1]}, 3'b000)
		`CMP(hp_comm_level_o, 3'(lvl[1]))
		`CMP({dub_mic_o, comm_active_o}, 4'hC)
		hit(0, K_C2);
		`CMP(msg_cnt != 16'h0000, 1'b1)
		final_report();
	end
	initial
	begin
		step(30000);
		n_fail++;
		final_report();
	end
endmodule : tb_monitor_console_control
`default_nettype wire
